// ===== rtl/dual_comparator_irq_ctrl.sv
// register bank, edge flags and interrupt requests for two analog comparators
// assumes comparator outputs arrive asynchronously and the bus is synchronous to clk
`timescale 1ns/1ps

module dual_comparator_irq_ctrl
  import cmp_irq_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic cmp_raw_a,
  input wire logic cmp_raw_b,
  output logic cmp_a_on,
  output logic cmp_b_on,
  output logic [1:0] cmp_a_speed_sel,
  output logic [1:0] cmp_b_speed_sel,
  output logic [1:0] cmp_a_pos_hyst_sel,
  output logic [1:0] cmp_a_neg_hyst_sel,
  output logic [1:0] cmp_b_pos_hyst_sel,
  output logic [1:0] cmp_b_neg_hyst_sel,
  output logic cmp_a_pin,
  output logic cmp_b_pin,
  output logic cmp_a_irq,
  output logic cmp_b_irq
);

  // index 0 is comparator a, index 1 is comparator b
  logic on [2];
  logic rise_flag [2];
  logic fall_flag [2];
  logic rise_en [2];
  logic fall_en [2];
  logic [1:0] speed [2];
  logic [1:0] hyp [2];
  logic [1:0] hyn [2];
  logic sync1 [2];
  logic sync2 [2];
  logic prev [2];
  logic result [2];
  logic raw [2];
  logic wr_ctrl [2];
  logic wr_mode [2];
  logic rise_ev [2];
  logic fall_ev [2];

  // hardware set wins over a software clear in the same cycle
  function automatic logic next_flag(input logic cur, input logic wr, input logic wval, input logic set);
    next_flag = set | (wr ? wval : cur);
  endfunction : next_flag

  // readback image of one control register
  function automatic logic [7:0] ctrl_image(input logic en, input logic res, input logic rf, input logic ff,
                                            input logic [1:0] p, input logic [1:0] n);
    ctrl_image = 8'h00;
    ctrl_image[CTRL_ON_BIT] = en;
    ctrl_image[CTRL_RESULT_BIT] = res;
    ctrl_image[CTRL_RISE_BIT] = rf;
    ctrl_image[CTRL_FALL_BIT] = ff;
    ctrl_image[CTRL_HYP_LSB +: 2] = p;
    ctrl_image[CTRL_HYN_LSB +: 2] = n;
  endfunction : ctrl_image

  // readback image of one mode register, unused bits read zero
  function automatic logic [7:0] mode_image(input logic re, input logic fe, input logic [1:0] s);
    mode_image = 8'h00;
    mode_image[MODE_RIE_BIT] = re;
    mode_image[MODE_FIE_BIT] = fe;
    mode_image[MODE_SPD_LSB +: 2] = s;
  endfunction : mode_image

  // address decode and edge events
  always_comb begin
    raw[0] = cmp_raw_a;
    raw[1] = cmp_raw_b;
    wr_ctrl[0] = sfr_wr && (sfr_addr == ADDR_A_CTRL);
    wr_ctrl[1] = sfr_wr && (sfr_addr == ADDR_B_CTRL);
    wr_mode[0] = sfr_wr && (sfr_addr == ADDR_A_MODE);
    wr_mode[1] = sfr_wr && (sfr_addr == ADDR_B_MODE);
    for (int i = 0; i < 2; i++) begin
      // edges only count while powered; disabled means suspended
      rise_ev[i] = on[i] && sync2[i] && !prev[i];
      fall_ev[i] = on[i] && !sync2[i] && prev[i];
    end
  end

  // two-stage synchroniser plus history stage for edge detection
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (rst) begin
        sync1[i] <= 1'b0;
        sync2[i] <= 1'b0;
        prev[i] <= 1'b0;
      end else begin
        sync1[i] <= raw[i];
        sync2[i] <= sync1[i];
        prev[i] <= sync2[i];
      end
    end
  end

  // routed output is registered low from the cycle after the comparator is switched off
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (rst) begin
        result[i] <= 1'b0;
      end else begin
        result[i] <= on[i] & sync2[i];
      end
    end
  end

  // control registers; the result bit is read-only
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (rst) begin
        on[i] <= CTRL_RESET[CTRL_ON_BIT];
        hyp[i] <= CTRL_RESET[CTRL_HYP_LSB +: 2];
        hyn[i] <= CTRL_RESET[CTRL_HYN_LSB +: 2];
      end else if (wr_ctrl[i]) begin
        on[i] <= sfr_wdata[CTRL_ON_BIT];
        hyp[i] <= sfr_wdata[CTRL_HYP_LSB +: 2];
        hyn[i] <= sfr_wdata[CTRL_HYN_LSB +: 2];
      end
    end
  end

  // sticky edge flags, cleared only by a software write of zero
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (rst) begin
        rise_flag[i] <= CTRL_RESET[CTRL_RISE_BIT];
        fall_flag[i] <= CTRL_RESET[CTRL_FALL_BIT];
      end else begin
        rise_flag[i] <= next_flag(rise_flag[i], wr_ctrl[i], sfr_wdata[CTRL_RISE_BIT], rise_ev[i]);
        fall_flag[i] <= next_flag(fall_flag[i], wr_ctrl[i], sfr_wdata[CTRL_FALL_BIT], fall_ev[i]);
      end
    end
  end

  // mode registers: interrupt enables and response-time field
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (rst) begin
        rise_en[i] <= MODE_RESET[MODE_RIE_BIT];
        fall_en[i] <= MODE_RESET[MODE_FIE_BIT];
        speed[i] <= MODE_RESET[MODE_SPD_LSB +: 2];
      end else if (wr_mode[i]) begin
        rise_en[i] <= sfr_wdata[MODE_RIE_BIT];
        fall_en[i] <= sfr_wdata[MODE_FIE_BIT];
        speed[i] <= sfr_wdata[MODE_SPD_LSB +: 2];
      end
    end
  end

  // registered read data, unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      unique case (sfr_addr)
        ADDR_A_CTRL: sfr_rdata <= ctrl_image(on[0], result[0], rise_flag[0], fall_flag[0], hyp[0], hyn[0]);
        ADDR_B_CTRL: sfr_rdata <= ctrl_image(on[1], result[1], rise_flag[1], fall_flag[1], hyp[1], hyn[1]);
        ADDR_A_MODE: sfr_rdata <= mode_image(rise_en[0], fall_en[0], speed[0]);
        ADDR_B_MODE: sfr_rdata <= mode_image(rise_en[1], fall_en[1], speed[1]);
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

  // analog-side controls; b has the same set as a, no reset-source output exists
  assign cmp_a_on = on[0];
  assign cmp_b_on = on[1];
  assign cmp_a_speed_sel = speed[0];
  assign cmp_b_speed_sel = speed[1];
  assign cmp_a_pos_hyst_sel = hyp[0];
  assign cmp_a_neg_hyst_sel = hyn[0];
  assign cmp_b_pos_hyst_sel = hyp[1];
  assign cmp_b_neg_hyst_sel = hyn[1];
  assign cmp_a_pin = result[0];
  assign cmp_b_pin = result[1];

  // request levels; stale flags from power-up are software's to clear first
  assign cmp_a_irq = on[0] && ((rise_flag[0] && rise_en[0]) || (fall_flag[0] && fall_en[0]));
  assign cmp_b_irq = on[1] && ((rise_flag[1] && rise_en[1]) || (fall_flag[1] && fall_en[1]));

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_irq_a_rise: assert property (on[0] && rise_flag[0] |-> (cmp_a_irq == rise_en[0] || (fall_flag[0] && fall_en[0])))
    else $error("comparator a rising request not gated by its enable");
  a_irq_a_fall: assert property (on[0] && fall_flag[0] && !rise_flag[0] |-> cmp_a_irq == fall_en[0])
    else $error("comparator a falling request not gated by its enable");
  a_irq_b_rise: assert property (on[1] && rise_flag[1] && !fall_flag[1] |-> cmp_b_irq == rise_en[1])
    else $error("comparator b rising request not gated by its enable");
  a_irq_b_fall: assert property (on[1] && fall_flag[1] && !rise_flag[1] |-> cmp_b_irq == fall_en[1])
    else $error("comparator b falling request not gated by its enable");
  a_speed_write: assert property (wr_mode[0] |=> cmp_a_speed_sel == $past(sfr_wdata[MODE_SPD_LSB +: 2]))
    else $error("comparator a speed field did not take the written value");
  a_rise_from_pin: assert property ($rose(cmp_raw_b) && on[1] ##1 (cmp_raw_b && on[1])[*2] |=> rise_flag[1])
    else $error("comparator b rising edge did not set its flag three cycles later");
  a_fall_sets: assert property (fall_ev[0] |=> fall_flag[0])
    else $error("comparator a falling edge did not set its flag");
  a_flag_sticky: assert property (rise_flag[1] && !(wr_ctrl[1] && !sfr_wdata[CTRL_RISE_BIT]) |=> rise_flag[1])
    else $error("comparator b rising flag cleared without a software write");
  a_off_silent: assert property (!on[0] ##1 !on[0] |-> !cmp_a_pin && !cmp_a_irq)
    else $error("disabled comparator a drove its pin or requested an interrupt");

endmodule : dual_comparator_irq_ctrl

// ===== shared/cmp_irq_pkg.sv
// constants for the dual comparator control and interrupt block
// assumes an 8-bit special-function-register bus with byte addresses
package cmp_irq_pkg;

  // register addresses on the special-function-register bus
  localparam logic [7:0] ADDR_B_CTRL = 8'h88;
  localparam logic [7:0] ADDR_A_MODE = 8'h89;
  localparam logic [7:0] ADDR_A_CTRL = 8'h8a;
  localparam logic [7:0] ADDR_B_MODE = 8'h8b;

  // control register fields (same layout for both comparators)
  localparam int CTRL_ON_BIT = 7;
  localparam int CTRL_RESULT_BIT = 6;
  localparam int CTRL_RISE_BIT = 5;
  localparam int CTRL_FALL_BIT = 4;
  localparam int CTRL_HYP_LSB = 2;
  localparam int CTRL_HYN_LSB = 0;

  // mode select register fields
  localparam int MODE_RIE_BIT = 5;
  localparam int MODE_FIE_BIT = 4;
  localparam int MODE_SPD_LSB = 0;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h02;

endpackage : cmp_irq_pkg

// ===== verif/dual_comparator_irq_ctrl_bench.sv
// bench for the dual comparator register bank, edge flags and interrupt requests
// assumes cmp_irq_pkg is compiled first; all inputs change on the falling clock edge
`timescale 1ns/1ps

module dual_comparator_irq_ctrl_bench import cmp_irq_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic [1:0] raw = 2'b00; // index 1 is comparator b
  logic [1:0] on, pin, irq;
  logic [1:0][1:0] spd, hp, hn;
  logic [1:0] c;
  logic [7:0] ra[5] = '{ADDR_B_CTRL, ADDR_A_MODE, ADDR_A_CTRL, ADDR_B_MODE, 8'h90};
  logic [7:0] rv[5] = '{CTRL_RESET, MODE_RESET, CTRL_RESET, MODE_RESET, 8'h00};
  int num_errors = 0;
  int n_checks = 0;

  // 100 MHz system clock
  always #5 clk = ~clk;

  dual_comparator_irq_ctrl dut (
    .clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cmp_raw_a(raw[0]), .cmp_raw_b(raw[1]),
    .cmp_a_on(on[0]), .cmp_b_on(on[1]), .cmp_a_speed_sel(spd[0]), .cmp_b_speed_sel(spd[1]),
    .cmp_a_pos_hyst_sel(hp[0]), .cmp_a_neg_hyst_sel(hn[0]),
    .cmp_b_pos_hyst_sel(hp[1]), .cmp_b_neg_hyst_sel(hn[1]),
    .cmp_a_pin(pin[0]), .cmp_b_pin(pin[1]), .cmp_a_irq(irq[0]), .cmp_b_irq(irq[1])
  );

  // one comparison, counted; four-state so an unknown never matches
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // strobes last one cycle; the idle cycle after keeps each driver to one change per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    check("sfr_rdata", sfr_rdata & m, exp);
  endtask : rd

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  // full edge, mask and disable sequence for one comparator; four cycles cover the synchroniser
  task automatic run_cmp(input int s);
    logic [7:0] ca;
    logic [7:0] ma;
    ca = s ? ADDR_B_CTRL : ADDR_A_CTRL;
    ma = s ? ADDR_B_MODE : ADDR_A_MODE;
    wr(ma, 8'h00);
    wr(ca, 8'hce); // result bit is read only
    repeat (4) @(negedge clk);
    wr(ca, 8'h8e); // clear flags left stale by power-up
    rd(ca, 8'hff, 8'h8e);
    check("on", {7'h00, on[s]}, 8'h01);
    check("hyst_sel", {4'h0, hp[s], hn[s]}, 8'h0e);
    raw[s] = 1'b1;
    repeat (4) @(negedge clk);
    check("pin", {7'h00, pin[s]}, 8'h01);
    rd(ca, 8'hff, 8'hee);
    check("irq", {7'h00, irq[s]}, 8'h00);
    wr(ma, 8'h20);
    check("irq", {7'h00, irq[s]}, 8'h01);
    raw[s] = 1'b0;
    repeat (4) @(negedge clk);
    rd(ca, 8'hff, 8'hbe);
    wr(ma, 8'h10);
    check("irq", {7'h00, irq[s]}, 8'h01);
    wr(ca, 8'h8e);
    check("irq", {7'h00, irq[s]}, 8'h00);
    wr(ma, 8'h30);
    // switch off with a software-set fall flag, so only the disable can hold irq low
    wr(ca, 8'h1e);
    check("on", {7'h00, on[s]}, 8'h00);
    raw[s] = 1'b1;
    repeat (4) @(negedge clk);
    check("pin", {7'h00, pin[s]}, 8'h00);
    check("irq", {7'h00, irq[s]}, 8'h00);
    rd(ca, 8'hf0, 8'h10);
    raw[s] = 1'b0;
    repeat (4) @(negedge clk);
  endtask : run_cmp

  // main sequence: reset values, every speed code, then each comparator
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd(ra[i], 8'hff, rv[i]);
    end
    check("speed_sel", {4'h0, spd[1], spd[0]}, 8'h0a);
    for (int k = 0; k < 4; k++) begin
      c = k[1:0];
      wr(ADDR_A_MODE, {6'h33, c});
      wr(ADDR_B_MODE, {6'h33, ~c});
      rd(ADDR_A_MODE, 8'hff, {6'h00, c});
      check("speed_sel", {4'h0, spd[1], spd[0]}, {4'h0, ~c, c});
    end
    run_cmp(0);
    run_cmp(1);
    finish_test();
  end

  // cuts a hang short; the sequence needs far less than this
  initial begin
    #200us;
    num_errors++;
    finish_test();
  end
endmodule : dual_comparator_irq_ctrl_bench
